// ===== common/ads_defs.svh
// ads_defs: offsets, field positions, reset values and counts of the slave
// assumes inclusion by bare name from interface, modules and test bench
// Function
// - one bit per clock, 18 clocks least
// - data steady while clock high
// - repeated start keeps bus and speed
// - acknowledge holds data low on ninth pulse
// - not-acknowledge leaves data high on ninth
// - idle slave waits for start plus address
// - answer only fixed address 0110110
// - address last bit: 0 write, 1 read
// - acknowledge a matching address byte
// - fast timing after power-up, high-speed optional
// - master code gets not-acknowledge, enters high-speed
// - stop returns high-speed to fast timing
// - byte top bit picks setup or configuration
// - one or two bytes, any order
// - acknowledge every written data byte
// - setup bit 3 picks conversion clock
// - setup bit 2 picks bipolar or unipolar
// - setup bit 1 zero restores configuration
// - configuration scan, input pick, single/diff
// - read sends six ones then result
`ifndef ADS_DEFS_SVH
`define ADS_DEFS_SVH
`define ADS_SLV_ADDR    7'h36
`define ADS_MC_PREFIX   5'h01
`define ADS_ACK_SLOT    4'h8
`define ADS_LAST_BIT    4'h7
`define ADS_MIN_XFER    18
`define ADS_FS_KSPS_X10 222
`define ADS_HS_KSPS_X10 944
`define ADS_RES_W       10
`define ADS_FILL        6'h3F
`define ADS_CLR_CYCLES  2'h2
`define ADS_REG_BIT     7
`define ADS_SET_REF_HI  6
`define ADS_SET_REF_LO  4
`define ADS_SET_CLK     3
`define ADS_SET_POL     2
`define ADS_SET_RST     1
`define ADS_CFG_SCAN_HI 6
`define ADS_CFG_SCAN_LO 5
`define ADS_CFG_PICK    1
`define ADS_CFG_SGL     0
`define ADS_SETUP_RST   8'h82
`define ADS_CONFIG_RST  8'h01
`endif

// ===== common/ads_link_if.sv
// ads_link_if: signals between core logic and the bus-clock engine
// assumes the core owns resets and result, the engine the rest
`timescale 1ns/1ps
`include "ads_defs.svh"
interface ads_link_if;
    logic                  frame_rst_n; // clears frame state on stop
    logic                  link_rst_n;  // clears toggles on reset
    logic [`ADS_RES_W-1:0] result;      // held conversion result
    logic                  wr_tgl;      // flips per written byte
    logic [7:0]            wr_byte;     // last written byte
    logic                  hs_tgl;      // flips per master code
    logic                  rd_busy;     // read frame in progress
    logic                  sda_oe;      // pulls data low
    logic                  ack_slot;    // ninth pulse under way
    modport core (output frame_rst_n, link_rst_n, result,
                  input wr_tgl, wr_byte, hs_tgl, rd_busy, sda_oe, ack_slot);
    modport link (input frame_rst_n, link_rst_n, result,
                  output wr_tgl, wr_byte, hs_tgl, rd_busy, sda_oe, ack_slot);
endinterface : ads_link_if

// ===== common/ads_pkg.sv
// ads_pkg: types shared by the slave modules
// assumes ads_defs.svh on the include path
package ads_pkg;
    // frame phase of the bit engine
    typedef enum logic [1:0] {
        ADS_M_ADDR,
        ADS_M_WRITE,
        ADS_M_READ,
        ADS_M_IGNORE
    } ads_mode_t;
endpackage : ads_pkg

// ===== logic/ads_link.sv
// ads_link: bit engine clocked by the bus clock
// assumes scl is the link clock and data moves only while it is low
`timescale 1ns/1ps
`include "ads_defs.svh"
module ads_link
    import ads_pkg::*;
(
    // bus pins
    input  wire logic scl,
    input  wire logic sda_in,
    // core side
    ads_link_if.link  lk
);
    ads_mode_t   mode;     // frame phase
    logic [3:0]  bitcnt;   // bits of current byte
    logic [6:0]  shreg;    // bits taken so far
    logic        ack_en;   // pull low in ack slot
    logic        rise_sda; // data at last rise
    logic        st_tgl;   // start seen at fall
    logic        st_ack;   // start taken at rise
    logic        byte_sel; // low result byte next
    logic        tx_live;  // result bytes flowing
    logic [15:0] tx_word;  // ones then result
    logic [7:0]  rx_byte;  // byte closing now
    logic        restart;  // start awaits first bit

    assign rx_byte = {shreg, sda_in};
    assign restart = st_tgl != st_ack;

    // sample side: shift, count, decode
    always_ff @(posedge scl or negedge lk.frame_rst_n) begin
        if (!lk.frame_rst_n) begin
            mode <= ADS_M_ADDR;
            bitcnt <= 4'h0;
            shreg <= 7'h00;
            ack_en <= 1'b0;
            rise_sda <= 1'b1;
            st_ack <= 1'b0;
            byte_sel <= 1'b0;
            tx_live <= 1'b0;
            tx_word <= 16'h0000;
            lk.rd_busy <= 1'b0;
            lk.ack_slot <= 1'b0;
        end else begin
            rise_sda <= sda_in;
            if (restart) begin // first address bit, speed kept
                st_ack <= st_tgl;
                mode <= ADS_M_ADDR;
                bitcnt <= 4'h1;
                shreg <= {6'h00, sda_in};
                ack_en <= 1'b0;
                tx_live <= 1'b0;
                lk.rd_busy <= 1'b0;
                lk.ack_slot <= 1'b0;
            end else if (bitcnt == `ADS_ACK_SLOT) begin
                bitcnt <= 4'h0;
                lk.ack_slot <= 1'b0;
                if (mode == ADS_M_READ) begin
                    if (tx_live && sda_in) begin // master declined more
                        mode <= ADS_M_IGNORE;
                        lk.rd_busy <= 1'b0;
                    end else begin
                        byte_sel <= tx_live ? ~byte_sel : 1'b0;
                        if (!tx_live || byte_sel)
                            tx_word <= {`ADS_FILL, lk.result};
                        tx_live <= 1'b1;
                    end
                end
            end else if (mode != ADS_M_IGNORE) begin
                bitcnt <= bitcnt + 4'h1;
                shreg <= rx_byte[6:0];
                if (bitcnt == `ADS_LAST_BIT) begin
                    lk.ack_slot <= 1'b1;
                    ack_en <= 1'b0;
                    case (mode)
                        ADS_M_ADDR: begin
                            if (rx_byte[7:1] == `ADS_SLV_ADDR) begin
                                ack_en <= 1'b1;
                                mode <= rx_byte[0] ? ADS_M_READ : ADS_M_WRITE;
                                lk.rd_busy <= rx_byte[0];
                            end else begin
                                mode <= ADS_M_IGNORE; // master code left high
                            end
                        end
                        ADS_M_WRITE: ack_en <= 1'b1;
                        default: ack_en <= 1'b0;
                    endcase
                end
            end
        end
    end

    // byte and master-code events toward the core
    always_ff @(posedge scl or negedge lk.link_rst_n) begin
        if (!lk.link_rst_n) begin
            lk.wr_tgl <= 1'b0;
            lk.wr_byte <= 8'h00;
            lk.hs_tgl <= 1'b0;
        end else if (!restart && bitcnt == `ADS_LAST_BIT) begin
            if (mode == ADS_M_WRITE) begin
                lk.wr_byte <= rx_byte;
                lk.wr_tgl <= ~lk.wr_tgl;
            end
            if (mode == ADS_M_ADDR && rx_byte[7:3] == `ADS_MC_PREFIX)
                lk.hs_tgl <= ~lk.hs_tgl;
        end
    end

    // drive side: start watch and data pull-down
    always_ff @(negedge scl or negedge lk.frame_rst_n) begin
        if (!lk.frame_rst_n) begin
            st_tgl <= 1'b0;
            lk.sda_oe <= 1'b0;
        end else if (rise_sda && !sda_in) begin // fall while high
            st_tgl <= ~st_tgl;
            lk.sda_oe <= 1'b0;
        end else if (bitcnt == `ADS_ACK_SLOT) begin
            lk.sda_oe <= ack_en;
        end else if (mode == ADS_M_READ && tx_live) begin
            lk.sda_oe <= ~tx_word[{~byte_sel, ~bitcnt[2:0]}];
        end else begin
            lk.sda_oe <= 1'b0;
        end
    end
endmodule : ads_link

// ===== logic/ads_slave.sv
// ads_slave: two-wire slave front end with setup and configuration store
// assumes pins pulled high outside; scl comes from the bus master
`timescale 1ns/1ps
`include "ads_defs.svh"
module ads_slave
    import ads_pkg::*;
#(
    parameter int SYNC_STAGES = 2 // pin synchroniser depth
)
(
    // core clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  resetn,
    // bus pins
    input  wire logic                  scl,
    input  wire logic                  sda_i,
    output logic                       sda_o,
    output logic                       sda_oe,
    // result from the converter
    input  wire logic [`ADS_RES_W-1:0] conv_result,
    // setup fields
    output logic                       refsel_bit2,
    output logic                       refsel_bit1,
    output logic                       refsel_bit0,
    output logic                       conv_clk_ext,
    output logic                       polarity_select,
    // configuration fields
    output logic                       scan_sel_hi,
    output logic                       scan_sel_lo,
    output logic                       input_pick,
    output logic                       single_vs_diff,
    // bus speed
    output logic                       hs_mode
);
    // elaboration check
    if (SYNC_STAGES < 2) begin : g_bad_sync
        $error("SYNC_STAGES must be at least 2");
    end

    // sync lane positions
    localparam int L_SCL = 0;
    localparam int L_SDA = 1;
    localparam int L_WR  = 2;
    localparam int L_HS  = 3;
    localparam int L_RD  = 4;

    // reset release
    logic [1:0] rst_pipe; // release pipeline
    logic       rst_n;    // released reset

    // synchronisers
    logic [4:0] sy [SYNC_STAGES]; // stage flops
    logic [4:0] raw;              // lanes entering
    logic [4:0] last;             // lanes settled
    logic [4:0] prv;              // settled, one later

    // events
    logic stop_evt; // stop on the bus
    logic wr_evt;   // new written byte
    logic hs_evt;   // master code seen
    logic rd_busy_s; // read frame running

    // stores
    logic [7:0]            converter_setup;  // last setup byte
    logic [7:0]            converter_config; // last config byte
    logic [1:0]            clr_cnt;          // frame clear length
    logic [`ADS_RES_W-1:0] result_hold;      // result for reads

    // carrier to the bit engine
    ads_link_if lk ();

    // setup or configuration byte
    function automatic logic is_setup(input logic [7:0] b);
        return b[`ADS_REG_BIT];
    endfunction : is_setup

    // setup byte asks for config defaults
    function automatic logic cfg_wipe(input logic [7:0] b);
        return is_setup(b) && !b[`ADS_SET_RST];
    endfunction : cfg_wipe

    // reset released through two flops
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe[1];

    // lanes crossing into the core clock
    assign raw = {lk.rd_busy, lk.hs_tgl, lk.wr_tgl, sda_i, scl};

    // stage chain, first flop feeds only the next
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < SYNC_STAGES; i++) begin
                sy[i] <= 5'h03;
            end
        end else begin
            sy[0] <= raw;
            for (int i = 1; i < SYNC_STAGES; i++) begin
                sy[i] <= sy[i-1];
            end
        end
    end
    assign last = sy[SYNC_STAGES-1];

    // settled lanes one cycle later, for edges
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prv <= 5'h03;
        end else begin
            prv <= last;
        end
    end

    // data rising with clock high ends the frame
    assign stop_evt = last[L_SCL] && prv[L_SCL]
                      && last[L_SDA] && !prv[L_SDA];
    // toggles mark engine events
    assign wr_evt = last[L_WR] ^ prv[L_WR];
    assign hs_evt = last[L_HS] ^ prv[L_HS];
    assign rd_busy_s = last[L_RD];

    // frame clear length after stop
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            clr_cnt <= 2'h0;
        end else if (stop_evt) begin
            clr_cnt <= `ADS_CLR_CYCLES;
        end else if (clr_cnt != 2'h0) begin
            clr_cnt <= clr_cnt - 2'h1;
        end
    end

    // engine frame reset, low on reset and after stop
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lk.frame_rst_n <= 1'b0;
        end else begin
            lk.frame_rst_n <= !(stop_evt || clr_cnt > 2'h1);
        end
    end

    // engine toggle reset follows core reset
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lk.link_rst_n <= 1'b0;
        end else begin
            lk.link_rst_n <= 1'b1;
        end
    end

    // result frozen while a read runs
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            result_hold <= '0;
        end else if (!rd_busy_s) begin
            result_hold <= conv_result;
        end
    end
    assign lk.result = result_hold;

    // setup byte store
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            converter_setup <= `ADS_SETUP_RST;
        end else if (wr_evt && is_setup(lk.wr_byte)) begin
            converter_setup <= lk.wr_byte;
        end
    end

    // configuration byte store
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            converter_config <= `ADS_CONFIG_RST;
        end else if (wr_evt && cfg_wipe(lk.wr_byte)) begin
            converter_config <= `ADS_CONFIG_RST;
        end else if (wr_evt && !is_setup(lk.wr_byte)) begin
            converter_config <= lk.wr_byte;
        end
    end

    // speed: master code sets, stop clears, restart keeps
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hs_mode <= 1'b0;
        end else if (hs_evt) begin
            hs_mode <= 1'b1;
        end else if (stop_evt) begin
            hs_mode <= 1'b0;
        end
    end

    // data pin only ever pulls low
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sda_o <= 1'b0;
        end else begin
            sda_o <= 1'b0;
        end
    end

    // field outputs straight off the stores
    assign refsel_bit2     = converter_setup[`ADS_SET_REF_HI];
    assign refsel_bit1     = converter_setup[`ADS_SET_REF_HI-1];
    assign refsel_bit0     = converter_setup[`ADS_SET_REF_LO];
    assign conv_clk_ext    = converter_setup[`ADS_SET_CLK];
    assign polarity_select = converter_setup[`ADS_SET_POL];
    assign scan_sel_hi     = converter_config[`ADS_CFG_SCAN_HI];
    assign scan_sel_lo     = converter_config[`ADS_CFG_SCAN_LO];
    assign input_pick      = converter_config[`ADS_CFG_PICK];
    assign single_vs_diff  = converter_config[`ADS_CFG_SGL];
    // pull-down enable is an engine flop
    assign sda_oe          = lk.sda_oe;

    // bit engine on the bus clock
    ads_link u_link (
        .scl    (scl),
        .sda_in (sda_i),
        .lk     (lk.link)
    );

    // stop seen on the pins
    sequence s_stop;
        stop_evt;
    endsequence

    // frame clear pulse of two cycles
    sequence s_clear;
        !lk.frame_rst_n [*2] ##1 lk.frame_rst_n;
    endsequence

    // stop clears the engine frame
    property p_stop_clear;
        @(posedge core_clk) disable iff (!rst_n)
        s_stop |=> s_clear;
    endproperty
    a_stop_frame_clear: assert property (p_stop_clear)
        else $error("frame clear after stop is wrong");

    // stop drops high-speed
    a_stop_fs_mode: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        s_stop and !hs_evt |=> !hs_mode)
        else $error("high-speed kept after stop");

    // master code raises high-speed
    a_mc_hs_entry: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        hs_evt |=> hs_mode)
        else $error("master code did not raise high-speed");

    // high-speed lasts until a stop
    a_hs_hold_restart: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        hs_mode && !stop_evt |=> hs_mode)
        else $error("high-speed lost without stop");

    // setup byte fields land
    a_setup_fields: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        wr_evt && is_setup(lk.wr_byte)
        |=> conv_clk_ext == $past(lk.wr_byte[`ADS_SET_CLK])
            && polarity_select == $past(lk.wr_byte[`ADS_SET_POL])
            && refsel_bit0 == $past(lk.wr_byte[`ADS_SET_REF_LO]))
        else $error("setup byte fields not stored");

    // configuration byte fields land
    a_config_fields: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        wr_evt && !is_setup(lk.wr_byte)
        |=> single_vs_diff == $past(lk.wr_byte[`ADS_CFG_SGL])
            && input_pick == $past(lk.wr_byte[`ADS_CFG_PICK])
            && scan_sel_hi == $past(lk.wr_byte[`ADS_CFG_SCAN_HI]))
        else $error("configuration byte fields not stored");

    // setup bit 1 low restores config defaults
    a_config_restore: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        wr_evt && cfg_wipe(lk.wr_byte)
        |=> converter_config == `ADS_CONFIG_RST
            && polarity_select == $past(lk.wr_byte[`ADS_SET_POL]))
        else $error("configuration not restored");

    // setup bit 1 high leaves config alone
    a_config_kept: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        wr_evt && is_setup(lk.wr_byte) && lk.wr_byte[`ADS_SET_RST]
        |=> $stable(converter_config))
        else $error("configuration changed by setup byte");

    // result frozen for a read
    a_read_freeze: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        rd_busy_s ##1 rd_busy_s |-> $stable(result_hold))
        else $error("result moved during read");

    // pull-down only in ack slots or reads
    a_oe_window: assert property (
        @(negedge scl) disable iff (!lk.frame_rst_n)
        $rose(lk.sda_oe) |-> $past(lk.ack_slot) || lk.rd_busy)
        else $error("data pulled low outside ack or read");

    // read address gets an acknowledge
    a_addr_ack_low: assert property (
        @(negedge scl) disable iff (!lk.frame_rst_n)
        lk.ack_slot && $rose(lk.rd_busy) |-> ##1 lk.sda_oe)
        else $error("read address not acknowledged");

    // written byte gets an acknowledge
    a_write_ack_low: assert property (
        @(negedge scl) disable iff (!lk.frame_rst_n)
        $changed(lk.wr_tgl) |-> ##1 lk.sda_oe)
        else $error("written byte not acknowledged");

    // master code left unacknowledged
    a_mc_nack_high: assert property (
        @(negedge scl) disable iff (!lk.frame_rst_n)
        $changed(lk.hs_tgl) |-> ##1 !lk.sda_oe)
        else $error("master code was acknowledged");

    // setup store moves only on a written byte
    a_setup_hold: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !wr_evt |=> $stable(converter_setup))
        else $error("setup byte changed without a write");

    // result follows the converter while no read runs
    a_result_track: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !rd_busy_s |=> result_hold == $past(conv_result))
        else $error("result not tracked outside reads");

    // engine frame clear drops the pull-down
    a_oe_frame_clr: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !lk.frame_rst_n |-> !sda_oe)
        else $error("data pulled low during frame clear");
endmodule : ads_slave

// ===== tb/adc_two_wire_slave_setup_test.sv
// adc_two_wire_slave_setup_test: self-checking bench for the two-wire slave
// assumes ads_bus_master as the far side and a pull-up on the data wire
`timescale 1ns/1ps
`include "ads_defs.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end
module adc_two_wire_slave_setup_test;
    logic                  core_clk;    // core clock
    logic                  resetn;      // reset, active low
    logic [`ADS_RES_W-1:0] conv_result; // converter result
    logic                  scl;         // link clock from master
    logic                  sda_rel;     // master releases data
    wire                   sda;         // resolved data wire
    logic                  sda_o, sda_oe, hs_mode;
    logic                  refsel_bit2, refsel_bit1, refsel_bit0;
    logic                  conv_clk_ext, polarity_select;
    logic                  scan_sel_hi, scan_sel_lo, input_pick, single_vs_diff;
    int                    failures  = 0;
    int                    cmp_count = 0;
    logic [15:0]           lfsr = 16'hE842; // seed 59458
    logic [7:0]            exp_set = `ADS_SETUP_RST;
    logic [7:0]            exp_cfg = `ADS_CONFIG_RST;

    // open drain: low when anyone pulls, else pulled up
    assign sda = sda_rel & ~(sda_oe & ~sda_o);

    ads_slave i_ads_slave (
        .core_clk(core_clk), .resetn(resetn), .scl(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe), .conv_result(conv_result),
        .refsel_bit2(refsel_bit2), .refsel_bit1(refsel_bit1),
        .refsel_bit0(refsel_bit0), .conv_clk_ext(conv_clk_ext),
        .polarity_select(polarity_select), .scan_sel_hi(scan_sel_hi),
        .scan_sel_lo(scan_sel_lo), .input_pick(input_pick),
        .single_vs_diff(single_vs_diff), .hs_mode(hs_mode));
    ads_bus_master i_ads_bus_master (.scl(scl), .sda_rel(sda_rel), .sda(sda));

    // core clock, 10 ns
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // next pseudo-random word
    function automatic logic [15:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction : rnd

    // expected store after one written byte
    function automatic void model_write(input logic [7:0] b);
        if (b[7]) begin
            exp_set = b;
            if (!b[1]) exp_cfg = `ADS_CONFIG_RST;
        end else begin
            exp_cfg = b;
        end
    endfunction : model_write

    // compare every field output with the model
    task automatic check_fields();
        `CHK("refsel", exp_set[6:4], {refsel_bit2, refsel_bit1, refsel_bit0})
        `CHK("clk_src", exp_set[3], conv_clk_ext)
        `CHK("polarity", exp_set[2], polarity_select)
        `CHK("scan", exp_cfg[6:5], {scan_sel_hi, scan_sel_lo})
        `CHK("pick", exp_cfg[1], input_pick)
        `CHK("sgl", exp_cfg[0], single_vs_diff)
    endtask : check_fields

    // write frame of one or two bytes, left open
    task automatic write_frame(input logic [7:0] b0, b1, input logic two);
        logic ack;
        i_ads_bus_master.start_c();
        i_ads_bus_master.put_byte({`ADS_SLV_ADDR, 1'b0}, ack);
        `CHK("addr ack", 1'b1, ack)
        i_ads_bus_master.put_byte(b0, ack);
        `CHK("data ack", 1'b1, ack)
        model_write(b0);
        if (two) begin
            i_ads_bus_master.put_byte(b1, ack);
            `CHK("data2 ack", 1'b1, ack)
            model_write(b1);
        end
    endtask : write_frame

    // verdict and end of run
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    // hang guard
    initial begin
        int cyc;
        cyc = 0;
        forever begin
            @(posedge core_clk);
            cyc++;
            if (cyc == 20000) begin
                failures++;
                end_of_test();
            end
        end
    end

    // main sequence
    initial begin
        logic [15:0] r;
        logic [6:0]  a;
        logic [7:0]  d;
        logic        ack;
        resetn      = 1'b0;
        conv_result = '0;
        repeat (16) @(posedge core_clk);
        @(negedge core_clk) resetn = 1'b1;
        repeat (12) @(negedge core_clk);
        check_fields();
        `CHK("hs reset", 1'b0, hs_mode)
        `CHK("sda_o", 1'b0, sda_o)
        // foreign addresses, one bit off first, then random
        for (int k = 0; k < 5; k++) begin
            r = rnd();
            a = (k == 0) ? 7'h37 : r[6:0];
            if (a == `ADS_SLV_ADDR || a[6:3] == 4'h0) a = a ^ 7'h40;
            i_ads_bus_master.start_c();
            i_ads_bus_master.put_byte({a, r[7]}, ack);
            `CHK("foreign ack", 1'b0, ack)
            i_ads_bus_master.put_byte({1'b1, r[14:8]}, ack);
            `CHK("ignored ack", 1'b0, ack)
            i_ads_bus_master.stop_c();
            check_fields();
        end
        // retry with own address: random writes, either order
        for (int k = 0; k < 8; k++) begin
            r = rnd();
            d = rnd();
            if (r[15]) write_frame({1'b1, r[6:0]}, {1'b0, r[14:8]}, d[0]);
            else write_frame({1'b0, r[14:8]}, {1'b1, r[6:0]}, d[0]);
            i_ads_bus_master.stop_c();
            check_fields();
        end
        // configuration all ones, then setup with restore bit low
        write_frame(8'h7F, 8'hF0, 1'b1);
        i_ads_bus_master.stop_c();
        check_fields();
        // master code, repeated start keeps high speed, stop leaves it
        for (int k = 0; k < 2; k++) begin
            r = rnd();
            i_ads_bus_master.start_c();
            i_ads_bus_master.put_byte({`ADS_MC_PREFIX, r[2:0]}, ack);
            `CHK("code nack", 1'b0, ack)
            repeat (6) @(negedge core_clk);
            `CHK("hs on", 1'b1, hs_mode)
            write_frame({1'b0, r[14:8]}, 8'h00, 1'b0);
            `CHK("hs kept", 1'b1, hs_mode)
            i_ads_bus_master.stop_c();
            `CHK("hs off", 1'b0, hs_mode)
            check_fields();
        end
        // read cycles: six ones, then result msb first
        for (int k = 0; k < 3; k++) begin
            r = rnd();
            @(negedge core_clk) conv_result = (k == 0) ? 10'h3FF : r[9:0];
            repeat (4) @(negedge core_clk);
            i_ads_bus_master.start_c();
            i_ads_bus_master.put_byte({`ADS_SLV_ADDR, 1'b1}, ack);
            `CHK("read ack", 1'b1, ack)
            i_ads_bus_master.get_byte(1'b1, d);
            `CHK("read hi", {`ADS_FILL, conv_result[9:8]}, d)
            i_ads_bus_master.get_byte(1'b0, d);
            `CHK("read lo", conv_result[7:0], d)
            i_ads_bus_master.stop_c();
            check_fields();
        end
        end_of_test();
    end
endmodule : adc_two_wire_slave_setup_test

// ===== tb/ads_bus_master.sv
// ads_bus_master: behavioural two-wire bus master, drives clock and open-drain data
// assumes pull-ups on both lines; sda is the resolved wire level
`timescale 1ns/1ps
module ads_bus_master (
    // bus pins
    output logic      scl,
    output logic      sda_rel,
    input  wire logic sda
);
    localparam real HALF = 15.0; // half of the 30 ns link period

    // idle: both lines high, clock stands still
    initial begin
        scl     = 1'b1;
        sda_rel = 1'b1;
    end

    // start or repeated start: data falls while clock high
    task automatic start_c();
        #3.3 sda_rel = 1'b1;
        #HALF scl = 1'b1;
        #HALF sda_rel = 1'b0;
        #HALF scl = 1'b0;
    endtask : start_c

    // one clock pulse; data changes only while clock low
    task automatic bit_c(input logic b, output logic seen);
        #7 sda_rel = b;
        #8 scl = 1'b1;
        #7 seen = sda;
        #8 scl = 1'b0;
    endtask : bit_c

    // byte out msb first, ninth pulse left to the receiver
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_c(d[i], s);
        bit_c(1'b1, s);
        ack = ~s;
    endtask : put_byte

    // byte in, then our own answer on the ninth pulse
    task automatic get_byte(input logic mack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_c(1'b1, s);
            d[i] = s;
        end
        bit_c(~mack, s);
    endtask : get_byte

    // stop: data rises while clock high, then bus-free time
    task automatic stop_c();
        #7 sda_rel = 1'b0;
        #8 scl = 1'b1;
        #HALF sda_rel = 1'b1;
        #60;
    endtask : stop_c
endmodule : ads_bus_master
